// ===== rtl/clk_fail_sleep_pkg.sv
package clk_fail_sleep_pkg;
  // register map
  localparam logic [7:0] FAIL_CTRL_STATUS_ADDR = 8'h62;
  localparam logic [7:0] SLEEP_CTRL_ADDR = 8'h53;
  localparam logic [7:0] BOD_CTRL_ADDR = 8'h55;
  localparam logic [7:0] FAIL_CTRL_STATUS_RESET = 8'h00;
  localparam int FAIL_FLAG_BIT = 1;
  localparam int FAIL_IE_BIT = 0;
  localparam int SLEEP_EN_BIT = 0;
  localparam int SLEEP_MODE_LSB = 1;
  localparam int BOD_SLEEP_BIT = 0;
  // clock source code of the calibrated rc oscillator
  localparam logic [3:0] SAFE_CLOCK_SOURCE = 4'h2;
  // safe clock is the rc clock divided down to 1 mhz
  localparam int RC_CLOCK_KHZ = 8000;
  localparam int SAFE_CLOCK_KHZ = 1000;
  localparam int SAFE_DIV = RC_CLOCK_KHZ / SAFE_CLOCK_KHZ;
  // wake timing
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_ADC_NR = 3'h1,
    MODE_PWR_DOWN = 3'h2,
    MODE_PWR_SAVE = 3'h3,
    MODE_RSVD4 = 3'h4,
    MODE_RSVD5 = 3'h5,
    MODE_STANDBY = 3'h6,
    MODE_EXT_STANDBY = 3'h7
  } sleep_mode_e;

  // clock domain gates, high means the domain runs
  typedef struct packed {
    logic cpu_clock_domain;
    logic flash_clock_domain;
    logic io_clock_domain;
    logic converter_clock_domain;
    logic async_timer_clock_domain;
    logic touch_clock_domain;
    logic main_osc_en;
    logic timer_osc_en;
  } clock_gates_s;

  // wake sources honoured in the current state
  typedef struct packed {
    logic ext_irq_edge_ok;
    logic ext_irq_level_ok;
    logic timer2_ok;
    logic converter_ok;
    logic uart_start_ok;
    logic other_io_ok;
  } wake_enables_s;
endpackage

// ===== rtl/clock_fail_and_sleep_control.sv
`timescale 1ns/1ps
// Behaviour
// - monitor and fallback act only when the fuse enable bit is one.
// - failure detection waits out oscillator start-up after every (re)start.
// - with monitoring enabled and no external clock, run from the rc oscillator.
// - a detected failure sets the failure flag, which stays set until reset.
// - interrupt is raised while failure flag and interrupt enable are both set.
// - detection is off in power-save and power-down, back on when active.
// - on failure, select the rc source and a 1 mhz safe clock.
// - the safe clock still passes through the software prescaler.
// - only power-on or external reset returns to the external clock.
// - rc fallback oscillator stays off until a failure is detected.
// - failure flag bit 1 is read-only, set by hardware, cleared by reset.
// - interrupt enable bit 0 can be set but never cleared by software.
// - sleep starts only with sleep enable set and a sleep instruction.
// - mode codes 000..011 idle/adc/down/save, 110 standby, 111 ext standby.
// - idle stops cpu and flash, adc adds io, power-down stops all.
// - timer oscillator and async domain in adc/save/ext standby only if async.
// - outside idle, the external irq pins wake only by level.
// - the serial receiver wakes only by start-of-frame detection.
// - in power-save, main clock keeps running while touch controller is on.
// - standby needs a crystal source; main oscillator stays on in standby.
// - wake from standby or extended standby within six cycles.
// - on wake by interrupt, hold cpu four cycles beyond start-up, then run.
// - wake leaves register file and sram contents untouched.
// - a reset during sleep wakes to the reset vector.
// - software brown-out disable only in down, save, standby, ext standby.
module clock_fail_and_sleep_control #(
  parameter int STARTUP_CYCLES = 16,
  parameter int MISS_LIMIT = 4,
  parameter int MON_DIV = 156
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // fuses and configuration
  input wire logic i_monitor_fuse,
  input wire logic i_crystal_selected,
  input wire logic [3:0] i_clock_source_select_fuse,
  input wire logic [3:0] i_prescale_sel,
  // external oscillator and peripherals
  input wire logic i_xosc_clk,
  input wire logic i_timer2_async,
  input wire logic i_touch_enabled,
  // cpu events
  input wire logic i_sleep_instr,
  input wire logic i_wake_irq,
  input wire logic i_wake_level_irq,
  input wire logic i_uart_start,
  input wire logic i_ext_reset,
  // clock outputs
  output logic [3:0] o_clock_source,
  output logic o_rc_osc_en,
  output logic o_safe_clk_en,
  output logic o_fail_irq,
  // sleep outputs
  output clk_fail_sleep_pkg::clock_gates_s o_gates,
  output clk_fail_sleep_pkg::wake_enables_s o_wake_en,
  output logic o_bod_off,
  output logic o_cpu_hold,
  output logic o_reset_vector
);
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} pm_state_e;

  pm_state_e state_reg;
  logic [2:0] mode_reg;
  logic sleep_en_reg;
  logic bod_sleep_reg;
  logic fail_flag_reg;
  logic fail_ie_reg;
  logic [1:0] xosc_sync_reg;
  logic xosc_prev_reg;
  logic [7:0] mon_div_reg;
  logic mon_tick;
  logic edge_seen_reg;
  logic [3:0] miss_reg;
  logic [15:0] startup_reg;
  logic [15:0] wake_cnt_reg;
  logic [2:0] safe_div_reg;
  logic [8:0] presc_cnt_reg;
  logic mon_active;
  logic is_standby;

  // two flops on the external oscillator before edge detection
  always_ff @(posedge i_clk) begin
    xosc_sync_reg <= {xosc_sync_reg[0], i_xosc_clk};
    xosc_prev_reg <= xosc_sync_reg[1];
  end

  // slow reference tick standing in for the 128 khz monitor clock
  always_ff @(posedge i_clk) begin
    if (i_rst || mon_div_reg == 8'(MON_DIV - 1)) begin
      mon_div_reg <= 8'h00;
    end else begin
      mon_div_reg <= mon_div_reg + 8'h01;
    end
  end
  assign mon_tick = (mon_div_reg == 8'(MON_DIV - 1));

  // detection is paused in power-down and power-save
  assign mon_active = i_monitor_fuse && !(state_reg == ST_SLEEP &&
    (mode_reg == clk_fail_sleep_pkg::MODE_PWR_DOWN ||
     mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE));

  // start-up blanking restarts whenever the oscillator is (re)started
  always_ff @(posedge i_clk) begin
    if (i_rst || !mon_active) begin
      startup_reg <= 16'(STARTUP_CYCLES);
    end else if (startup_reg != 16'h0000) begin
      startup_reg <= startup_reg - 16'h0001;
    end
  end

  // count reference ticks with no oscillator edge
  always_ff @(posedge i_clk) begin
    if (i_rst || !mon_active || startup_reg != 16'h0000) begin
      edge_seen_reg <= 1'b0;
      miss_reg <= 4'h0;
    end else if (mon_tick) begin
      edge_seen_reg <= 1'b0;
      miss_reg <= edge_seen_reg ? 4'h0 : miss_reg + 4'h1;
    end else if (xosc_sync_reg[1] != xosc_prev_reg) begin
      edge_seen_reg <= 1'b1;
    end
  end

  // sticky flag, only reset clears it; writes never touch it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fail_flag_reg <= 1'b0;
    end else if (mon_active && miss_reg >= 4'(MISS_LIMIT)) begin
      fail_flag_reg <= 1'b1;
    end
  end

  // enable can only be set by software
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fail_ie_reg <= 1'b0;
    end else if (i_wr && i_addr == clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR &&
                 i_wdata[clk_fail_sleep_pkg::FAIL_IE_BIT]) begin
      fail_ie_reg <= 1'b1;
    end
  end

  // sleep and brown-out control registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sleep_en_reg <= 1'b0;
      mode_reg <= 3'h0;
      bod_sleep_reg <= 1'b0;
    end else if (i_wr && i_addr == clk_fail_sleep_pkg::SLEEP_CTRL_ADDR) begin
      sleep_en_reg <= i_wdata[clk_fail_sleep_pkg::SLEEP_EN_BIT];
      mode_reg <= i_wdata[clk_fail_sleep_pkg::SLEEP_MODE_LSB +: 3];
    end else if (i_wr && i_addr == clk_fail_sleep_pkg::BOD_CTRL_ADDR) begin
      bod_sleep_reg <= i_wdata[clk_fail_sleep_pkg::BOD_SLEEP_BIT];
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= clk_fail_sleep_pkg::FAIL_CTRL_STATUS_RESET;
    end else if (i_rd) begin
      case (i_addr)
        clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR: begin
          o_rdata <= {6'h00, fail_flag_reg, fail_ie_reg};
        end
        clk_fail_sleep_pkg::SLEEP_CTRL_ADDR: begin
          o_rdata <= {4'h0, mode_reg, sleep_en_reg};
        end
        clk_fail_sleep_pkg::BOD_CTRL_ADDR: begin
          o_rdata <= {7'h00, bod_sleep_reg};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign is_standby = (mode_reg == clk_fail_sleep_pkg::MODE_STANDBY ||
                       mode_reg == clk_fail_sleep_pkg::MODE_EXT_STANDBY);

  // power state: reserved modes and standby without crystal are not entered
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_ACTIVE;
      wake_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_ACTIVE: begin
          if (i_sleep_instr && sleep_en_reg && mode_reg != clk_fail_sleep_pkg::MODE_RSVD4 &&
              mode_reg != clk_fail_sleep_pkg::MODE_RSVD5 &&
              (!is_standby || i_crystal_selected)) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (i_wake_irq || (i_wake_level_irq && o_wake_en.ext_irq_level_ok) ||
              (i_uart_start && o_wake_en.uart_start_ok)) begin
            state_reg <= ST_WAKE;
            if (is_standby) begin
              wake_cnt_reg <= 16'(clk_fail_sleep_pkg::STANDBY_WAKE_CYCLES - 1);
            end else if (mode_reg == clk_fail_sleep_pkg::MODE_IDLE ||
                         mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR) begin
              wake_cnt_reg <= 16'(clk_fail_sleep_pkg::WAKE_HALT_CYCLES - 1);
            end else begin
              wake_cnt_reg <= 16'(STARTUP_CYCLES + clk_fail_sleep_pkg::WAKE_HALT_CYCLES - 1);
            end
          end
        end
        ST_WAKE: begin
          if (wake_cnt_reg == 16'h0000) begin
            state_reg <= ST_ACTIVE;
          end else begin
            wake_cnt_reg <= wake_cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_ACTIVE;
        end
      endcase
    end
  end

  // domain gates per mode
  always_ff @(posedge i_clk) begin
    if (i_rst || state_reg != ST_SLEEP) begin
      o_gates <= '1;
    end else begin
      o_gates.cpu_clock_domain <= 1'b0;
      o_gates.flash_clock_domain <= 1'b0;
      o_gates.io_clock_domain <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE);
      o_gates.converter_clock_domain <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE ||
                                         mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR);
      o_gates.async_timer_clock_domain <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE) ||
        ((mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR ||
          mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE ||
          mode_reg == clk_fail_sleep_pkg::MODE_EXT_STANDBY) && i_timer2_async);
      o_gates.timer_osc_en <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE ||
        mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR ||
        mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE ||
        mode_reg == clk_fail_sleep_pkg::MODE_EXT_STANDBY) && i_timer2_async;
      o_gates.touch_clock_domain <= (mode_reg != clk_fail_sleep_pkg::MODE_PWR_DOWN &&
                                     mode_reg != clk_fail_sleep_pkg::MODE_STANDBY);
      o_gates.main_osc_en <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE) ||
        (mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR) || is_standby ||
        (mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE && i_touch_enabled);
    end
  end

  // wake source enables per mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wake_en <= '0;
    end else begin
      o_wake_en.ext_irq_edge_ok <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE);
      o_wake_en.ext_irq_level_ok <= 1'b1;
      o_wake_en.timer2_ok <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE) ||
        (mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE) ||
        (mode_reg == clk_fail_sleep_pkg::MODE_EXT_STANDBY) ||
        (mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR && i_timer2_async);
      o_wake_en.converter_ok <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE ||
                                 mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR);
      o_wake_en.uart_start_ok <= 1'b1;
      o_wake_en.other_io_ok <= (mode_reg == clk_fail_sleep_pkg::MODE_IDLE);
    end
  end

  // brown-out disable honoured only in the deep modes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bod_off <= 1'b0;
    end else begin
      o_bod_off <= bod_sleep_reg && state_reg == ST_SLEEP &&
        mode_reg != clk_fail_sleep_pkg::MODE_IDLE &&
        mode_reg != clk_fail_sleep_pkg::MODE_ADC_NR;
    end
  end

  // cpu hold while asleep or waking; reset during sleep goes to reset vector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cpu_hold <= 1'b0;
      o_reset_vector <= 1'b1;
    end else begin
      o_cpu_hold <= (state_reg != ST_ACTIVE);
      o_reset_vector <= i_ext_reset;
    end
  end

  // clock switching; rc stays off until a failure
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_clock_source <= 4'h0;
      o_rc_osc_en <= 1'b0;
      o_fail_irq <= 1'b0;
    end else begin
      o_clock_source <= (i_monitor_fuse && fail_flag_reg) ?
        clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE : i_clock_source_select_fuse;
      o_rc_osc_en <= i_monitor_fuse && fail_flag_reg;
      o_fail_irq <= fail_flag_reg && fail_ie_reg;
    end
  end

  // safe 1 mhz enable from rc divide, then the software prescaler
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_rc_osc_en) begin
      safe_div_reg <= 3'h0;
      presc_cnt_reg <= 9'h000;
      o_safe_clk_en <= 1'b0;
    end else begin
      safe_div_reg <= (safe_div_reg == 3'(clk_fail_sleep_pkg::SAFE_DIV - 1)) ?
        3'h0 : safe_div_reg + 3'h1;
      o_safe_clk_en <= 1'b0;
      if (safe_div_reg == 3'(clk_fail_sleep_pkg::SAFE_DIV - 1)) begin
        if (presc_cnt_reg >= 9'((9'h001 << i_prescale_sel) - 9'h001)) begin
          presc_cnt_reg <= 9'h000;
          o_safe_clk_en <= 1'b1;
        end else begin
          presc_cnt_reg <= presc_cnt_reg + 9'h001;
        end
      end
    end
  end

  a_irq_follows_flag: assert property (
    @(posedge i_clk) disable iff (i_rst) (fail_flag_reg && fail_ie_reg) |=> o_fail_irq)
    else $error("irq missing");
  a_flag_sticky: assert property (
    @(posedge i_clk) disable iff (i_rst) fail_flag_reg |=> fail_flag_reg)
    else $error("flag cleared");
  a_ie_sticky: assert property (
    @(posedge i_clk) disable iff (i_rst) fail_ie_reg |=> fail_ie_reg)
    else $error("enable cleared");
  a_no_fuse_no_fail: assert property (
    @(posedge i_clk) disable iff (i_rst) !i_monitor_fuse |=> !o_rc_osc_en)
    else $error("rc on without fuse");
  a_safe_source: assert property (
    @(posedge i_clk) disable iff (i_rst) (i_monitor_fuse && fail_flag_reg) |=>
    o_clock_source == clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE) else $error("no safe");
  a_rc_off_normal: assert property (
    @(posedge i_clk) disable iff (i_rst) !fail_flag_reg |=> !o_rc_osc_en)
    else $error("rc on early");
  a_no_sleep_wo_en: assert property (
    @(posedge i_clk) disable iff (i_rst) (state_reg == ST_ACTIVE && !sleep_en_reg) |=>
    state_reg == ST_ACTIVE) else $error("sleep without enable");
  a_standby_wake: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == ST_SLEEP && is_standby && i_wake_irq) |->
    ##[1:7] state_reg == ST_ACTIVE) else $error("standby wake slow");
  a_bod_shallow: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode_reg == clk_fail_sleep_pkg::MODE_IDLE || mode_reg == clk_fail_sleep_pkg::MODE_ADC_NR) &&
    $stable(mode_reg) |=> !o_bod_off) else $error("bod off in idle");
  a_no_detect_blank: assert property (
    @(posedge i_clk) disable iff (i_rst) startup_reg != 16'h0000 |=> $stable(fail_flag_reg))
    else $error("detect in blanking");
  a_no_detect_asleep: assert property (
    @(posedge i_clk) disable iff (i_rst) (state_reg == ST_SLEEP &&
    (mode_reg == clk_fail_sleep_pkg::MODE_PWR_DOWN ||
     mode_reg == clk_fail_sleep_pkg::MODE_PWR_SAVE)) |=> $stable(fail_flag_reg))
    else $error("detect while asleep");
  a_pd_gates_off: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == ST_SLEEP && mode_reg == clk_fail_sleep_pkg::MODE_PWR_DOWN) |=> o_gates == '0)
    else $error("power-down gates on");
  c_fail_seen: cover property (@(posedge i_clk) disable iff (i_rst) $rose(fail_flag_reg));
  c_sleep_wake: cover property (@(posedge i_clk) disable iff (i_rst)
    state_reg == ST_WAKE ##1 state_reg == ST_ACTIVE);
  c_safe_tick: cover property (@(posedge i_clk) disable iff (i_rst) o_safe_clk_en);
  c_standby_sleep: cover property (@(posedge i_clk) disable iff (i_rst)
    state_reg == ST_SLEEP && is_standby);
endmodule

// ===== test/xosc_model.sv
`timescale 1ns/1ps
// external oscillator standing in for the crystal on the far side
module xosc_model #(
  parameter realtime HALF_NS = 65.0
) (
  // control
  input wire logic i_run,
  // oscillator output
  output logic o_clk
);
  // a stopped crystal holds its last level, so a failure looks like a frozen line
  initial begin
    o_clk = 1'b0;
    forever begin
      #(HALF_NS);
      if (i_run) o_clk = ~o_clk;
    end
  end
endmodule

// ===== test/clock_fail_and_sleep_control_tb.sv
`timescale 1ns/1ps
module clock_fail_and_sleep_control_tb;
  localparam int STARTUP = 4;
  localparam logic [3:0] FUSE_CODE = 4'h5;
  logic i_clk, i_rst, i_wr, i_rd, i_monitor_fuse, i_crystal_selected, i_xosc_clk;
  logic i_sleep_instr, i_wake_irq, i_ext_reset, xosc_run, timer2_async, touch_enabled;
  logic [7:0] i_addr, i_wdata, o_rdata, rd_val;
  logic [3:0] i_prescale_sel, o_clock_source;
  logic o_rc_osc_en, o_safe_clk_en, o_fail_irq, o_bod_off, o_cpu_hold, o_reset_vector;
  clk_fail_sleep_pkg::clock_gates_s o_gates;
  clk_fail_sleep_pkg::wake_enables_s o_wake_en;
  int error_cnt, comparisons, n;
  logic [7:0] gate_tab [8];
  logic [7:0] wake_tab [8];
  logic [2:0] modes [6];

  clock_fail_and_sleep_control #(.STARTUP_CYCLES(STARTUP), .MISS_LIMIT(2), .MON_DIV(8)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_monitor_fuse(i_monitor_fuse),
    .i_crystal_selected(i_crystal_selected), .i_clock_source_select_fuse(FUSE_CODE),
    .i_prescale_sel(i_prescale_sel), .i_xosc_clk(i_xosc_clk), .i_timer2_async(timer2_async),
    .i_touch_enabled(touch_enabled), .i_sleep_instr(i_sleep_instr), .i_wake_irq(i_wake_irq),
    .i_wake_level_irq(1'b0), .i_uart_start(1'b0), .i_ext_reset(i_ext_reset),
    .o_clock_source(o_clock_source), .o_rc_osc_en(o_rc_osc_en),
    .o_safe_clk_en(o_safe_clk_en), .o_fail_irq(o_fail_irq), .o_gates(o_gates),
    .o_wake_en(o_wake_en), .o_bod_off(o_bod_off), .o_cpu_hold(o_cpu_hold),
    .o_reset_vector(o_reset_vector));

  xosc_model i_xosc (.i_run(xosc_run), .o_clk(i_xosc_clk));

  // 20 mhz system clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  // strobes rise after one edge and drop after the next, so each is one cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    step(6);
    i_rst <= 1'b0;
    step(3);
  endtask

  task automatic pulse_sleep(input logic [2:0] m, input logic en);
    reg_wr(clk_fail_sleep_pkg::SLEEP_CTRL_ADDR, {4'h0, m, en});
    @(posedge i_clk);
    i_sleep_instr <= 1'b1;
    @(posedge i_clk);
    i_sleep_instr <= 1'b0;
    step(3);
  endtask

  // bounded wait for the switch to the safe source
  task automatic wait_fail(input int limit);
    n = 0;
    while (o_clock_source !== clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE && n < limit) begin
      step(1);
      n++;
    end
  endtask

  // watchdog sized well above the whole sequence
  initial begin
    #(50 * 30000);
    error_cnt++;
    $display("FAIL watchdog expected done seen hang");
    summarize();
  end

  initial begin
    {i_rst, i_wr, i_rd, i_sleep_instr, i_wake_irq, i_ext_reset} = '0;
    {i_addr, i_wdata} = '0;
    i_prescale_sel = 4'h0;
    i_monitor_fuse = 1'b1;
    i_crystal_selected = 1'b1;
    timer2_async = 1'b1;
    touch_enabled = 1'b1;
    xosc_run = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    // expected gates per mode: cpu flash io adc asy touch main timer
    gate_tab = '{8'h3F, 8'h1F, 8'h00, 8'h0F, 8'hFF, 8'hFF, 8'h02, 8'h0F};
    modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    // expected wake sources per mode: edge level timer2 adc uart other
    wake_tab = '{8'h3F, 8'h1E, 8'h12, 8'h1A, 8'h00, 8'h00, 8'h12, 8'h1A};
    do_reset();

    // register reset values and access kinds
    reg_rd(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR);
    check("status reset", rd_val, clk_fail_sleep_pkg::FAIL_CTRL_STATUS_RESET);
    check("rc osc idle", {7'h0, o_rc_osc_en}, 8'h00);
    reg_wr(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR, 8'h03);
    reg_rd(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR);
    check("flag not writable", rd_val, 8'h01);
    reg_wr(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR, 8'h00);
    reg_rd(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR);
    check("enable sticks", rd_val, 8'h01);
    reg_rd(8'h7A);
    check("unmapped read", rd_val, 8'h00);
    $display("test registers done");

    // every mode with software brown-out disable requested
    reg_wr(clk_fail_sleep_pkg::BOD_CTRL_ADDR, 8'h01);
    foreach (modes[i]) begin
      pulse_sleep(modes[i], 1'b1);
      check("asleep", {7'h0, o_cpu_hold}, 8'h01);
      check("gates", o_gates, gate_tab[modes[i]]);
      check("edge wake", {6'h0, o_wake_en[5:4]}, (modes[i] == 3'h0) ? 8'h03 : 8'h01);
      check("start frame wake", {7'h0, o_wake_en[1]}, 8'h01);
      check("wake sources", {2'h0, o_wake_en}, wake_tab[modes[i]]);
      check("bod off", {7'h0, o_bod_off}, {7'h0, modes[i][1]});
      @(posedge i_clk);
      i_wake_irq <= 1'b1;
      @(posedge i_clk);
      i_wake_irq <= 1'b0;
      n = 1;
      while (o_cpu_hold !== 1'b0 && n < 100) begin
        step(1);
        n++;
      end
      case (modes[i])
        3'h0, 3'h1: check("wake time", 8'(n >= 4 && n <= 7), 8'h01);
        3'h6, 3'h7: check("wake time", 8'(n >= 6 && n <= 9), 8'h01);
        default: check("wake time", 8'(n >= STARTUP + 4 && n <= STARTUP + 7), 8'h01);
      endcase
      step(2);
      check("gates awake", o_gates, 8'hFF);
      check("bod back on", {7'h0, o_bod_off}, 8'h00);
    end
    $display("test sleep modes done");

    // power-save with a synchronous timer and the touch controller off
    timer2_async <= 1'b0;
    touch_enabled <= 1'b0;
    pulse_sleep(3'h3, 1'b1);
    check("save gates sync", o_gates, 8'h04);
    @(posedge i_clk);
    i_wake_irq <= 1'b1;
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
    step(STARTUP + 8);
    check("save woken", {7'h0, o_cpu_hold}, 8'h00);
    timer2_async <= 1'b1;
    touch_enabled <= 1'b1;
    $display("test sync save done");

    // sleep refused without enable, in a reserved mode, or standby without crystal
    pulse_sleep(3'h0, 1'b0);
    check("no enable", {7'h0, o_cpu_hold}, 8'h00);
    pulse_sleep(3'h4, 1'b1);
    check("reserved mode", {7'h0, o_cpu_hold}, 8'h00);
    i_crystal_selected <= 1'b0;
    pulse_sleep(3'h6, 1'b1);
    check("standby no crystal", {7'h0, o_cpu_hold}, 8'h00);
    i_crystal_selected <= 1'b1;
    $display("test refused sleep done");

    // no detection in power-down, back on after wake
    pulse_sleep(3'h2, 1'b1);
    xosc_run = 1'b0;
    step(80);
    check("source in sleep", o_clock_source, FUSE_CODE);
    @(posedge i_clk);
    i_wake_irq <= 1'b1;
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
    wait_fail(200);
    check("fail after wake", o_clock_source, clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE);
    $display("test sleep blanking done");

    // running oscillator, then a failure
    xosc_run = 1'b1;
    do_reset();
    check("source restored", o_clock_source, FUSE_CODE);
    reg_wr(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR, 8'h01);
    step(100);
    check("no false fail", {o_clock_source, 3'h0, o_rc_osc_en}, {FUSE_CODE, 4'h0});
    xosc_run = 1'b0;
    wait_fail(200);
    step(2);
    check("safe source", o_clock_source, clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE);
    check("rc on", {7'h0, o_rc_osc_en}, 8'h01);
    check("irq", {7'h0, o_fail_irq}, 8'h01);
    reg_rd(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR);
    check("flag set", rd_val, 8'h03);
    // safe clock rate, then software rescaling through the prescaler
    for (int s = 0; s < 2; s++) begin
      i_prescale_sel <= 4'(s);
      step(40);
      n = 0;
      repeat (128) begin
        step(1);
        if (o_safe_clk_en === 1'b1) n++;
      end
      check("safe clock pulses", 8'(n), 8'(128 / (clk_fail_sleep_pkg::SAFE_DIV << s)));
    end
    xosc_run = 1'b1;
    step(60);
    check("stays on safe", o_clock_source, clk_fail_sleep_pkg::SAFE_CLOCK_SOURCE);
    do_reset();
    reg_rd(clk_fail_sleep_pkg::FAIL_CTRL_STATUS_ADDR);
    check("flag cleared", rd_val, 8'h00);
    check("back to xosc", o_clock_source, FUSE_CODE);
    $display("test failure done");

    // reset during sleep goes to the reset vector
    pulse_sleep(3'h0, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_ext_reset <= 1'b1;
    step(2);
    check("reset vector", {7'h0, o_reset_vector}, 8'h01);
    check("woken", {7'h0, o_cpu_hold}, 8'h00);
    i_rst <= 1'b0;
    i_ext_reset <= 1'b0;
    step(3);
    $display("test reset in sleep done");

    // fuse off: no monitoring
    i_monitor_fuse <= 1'b0;
    do_reset();
    xosc_run = 1'b0;
    step(150);
    check("fuse off source", {o_clock_source, 3'h0, o_rc_osc_en}, {FUSE_CODE, 4'h0});
    check("fuse off irq", {7'h0, o_fail_irq}, 8'h00);
    $display("test fuse off done");
    summarize();
  end
endmodule
